// >>> inc/gfr_pkg.sv
// Purpose: constants and types for the receive packet control block
// Assumes: 250 MHz clock; flags are sixteen bits wide
// Notes:   flag bit positions are local choices
package gfr_pkg;
  localparam int          FLAG_W        = 16;
  localparam int          PKT_END_BIT   = 1;
  localparam int          SYNC_BIT      = 2;
  localparam int          CRC_BIT       = 6;
  localparam int          EXPIRY_BIT    = 14;
  localparam logic [15:0] CNT_SINGLE    = 16'h0000;
  localparam logic [15:0] CNT_CONT      = 16'hFFFF;
  localparam int          ST_MULTI_BIT  = 6;
  localparam int          ST_OVER_BIT   = 5;
  localparam int          ST_CRC_BIT    = 4;
  localparam int          ST_ABORT_BIT  = 3;
  localparam int          ST_HDR_BIT    = 2;
  localparam int          ST_DONE_BIT   = 1;
  localparam int          ST_BUSY_BIT   = 0;
  localparam logic [2:0]  CORR_NONE     = 3'h0;
  localparam logic [2:0]  CORR_ONE      = 3'h1;
  localparam logic [2:0]  CORR_TWO      = 3'h2;
  localparam logic [2:0]  CORR_THREE    = 3'h4;
  localparam logic [7:0]  RESET_BYTE    = 8'h00;
  // Step sizes in ns: 15.625 us, 62.5 us, 1 ms, 4 ms
  localparam int          STEP0_NS      = 15625;
  localparam int          STEP1_NS      = 62500;
  localparam int          STEP2_NS      = 1000000;
  localparam int          STEP3_NS      = 4000000;
  localparam int          CLK_NS        = 4;
  localparam int          STEP0_CYC     = STEP0_NS / CLK_NS;
  localparam int          STEP1_CYC     = STEP1_NS / CLK_NS;
  localparam int          STEP2_CYC     = STEP2_NS / CLK_NS;
  localparam int          STEP3_CYC     = STEP3_NS / CLK_NS;

  typedef enum logic [1:0] {
    GFR_IDLE = 2'b00,
    GFR_LISTEN = 2'b01,
    GFR_PACKET = 2'b10
  } gfr_state_t;
endpackage

// >>> hw/gfr_step_timer.sv
// Purpose: timeout step counter for receive window
// Assumes: step length given in clock cycles
// Notes:   tick pulses once per step while enabled
`timescale 1ns/1ps
module gfr_step_timer
  import gfr_pkg::*;
(
  // Clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        sys_rst_i,
  // Control
  input  wire logic        run_i,
  input  wire logic [21:0] step_len_i,
  // Status
  output logic             tick_o
);
  logic [21:0] cyc_r;
  logic [21:0] cyc_nxt;
  wire         at_end = (cyc_r + 22'h1 >= step_len_i);

  // Cycle counter restarts whenever the timer is halted
  assign cyc_nxt = (!run_i || at_end) ? 22'h0 : cyc_r + 22'h1;

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cyc_r  <= 22'h0;
      tick_o <= 1'b0;
    end else begin
      cyc_r  <= cyc_nxt;
      tick_o <= run_i && at_end;
    end
  end
endmodule // gfr_step_timer

// >>> hw/gfr_rx_ctrl.sv
// Purpose: receive packet control, flags, event pins and packet report
// Assumes: demodulator events arrive as one-cycle pulses on the clock
// Notes:   commands are one-cycle strobes with their arguments
`timescale 1ns/1ps
module gfr_rx_ctrl
  import gfr_pkg::*;
#(
  parameter int STEP3_LEN = STEP3_CYC
) (
  // Clock and reset
  input  wire logic          ref_clk_i,
  input  wire logic          sys_rst_i,
  // Receive start command, standby command and user abort
  input  wire logic          receive_start_cmd_i,
  input  wire logic [1:0]    timeout_step_size_i,
  input  wire logic [7:0]    timeout_step_count_hi_i,
  input  wire logic [7:0]    timeout_step_count_lo_i,
  input  wire logic          standby_cmd_i,
  input  wire logic          user_abort_i,
  // Pin routing command
  input  wire logic          pin_irq_routing_cmd_i,
  input  wire logic [15:0]   flag_enable_mask_i,
  input  wire logic [15:0]   pin1_mask_i,
  input  wire logic [15:0]   pin2_mask_i,
  input  wire logic [15:0]   pin3_mask_i,
  // Flag clear command
  input  wire logic          flag_clear_cmd_i,
  input  wire logic [15:0]   flag_select_mask_i,
  // Packet configuration
  input  wire logic          var_length_i,
  input  wire logic          crc_enable_i,
  input  wire logic          multi_sync_en_i,
  input  wire logic [7:0]    max_payload_len_i,
  input  wire logic [7:0]    rx_base_addr_i,
  // Demodulator events
  input  wire logic          sync_found_i,
  input  wire logic [2:0]    sync_which_i,
  input  wire logic          sync_again_i,
  input  wire logic [7:0]    strength_i,
  input  wire logic          header_i,
  input  wire logic [7:0]    hdr_len_i,
  input  wire logic          packet_done_i,
  input  wire logic          crc_bad_i,
  // Flags and pins
  output logic [15:0]        flags_o,
  output logic               pin1_o,
  output logic               pin2_o,
  output logic               pin3_o,
  output logic               receiving_o,
  // Packet report
  output logic [7:0]         sync_strength_o,
  output logic [7:0]         status2_o,
  output logic [7:0]         status4_o,
  // Buffer report
  output logic [7:0]         payload_len_o,
  output logic [7:0]         payload_start_addr_o,
  output logic               packet_store_o
);
  gfr_state_t  state_r, state_nxt;
  logic [15:0] count_r;
  logic [15:0] steps_r;
  logic [21:0] step_len;
  logic        tick;
  logic [15:0] en_r, m1_r, m2_r, m3_r;
  logic [15:0] flags_nxt;
  logic [15:0] set_vec;
  logic [7:0]  len_r;

  // Command arguments
  wire [15:0] cmd_count = {timeout_step_count_hi_i, timeout_step_count_lo_i};
  wire        cont_mode = (count_r == CNT_CONT);
  wire        single    = (count_r == CNT_SINGLE);
  wire        timed     = !single && !cont_mode;
  wire        in_rx     = (state_r != GFR_IDLE);
  wire        oversize  = var_length_i && header_i &&
                          (hdr_len_i > max_payload_len_i);
  // A dropped packet never reports an end
  wire        pkt_end   = packet_done_i && (state_r == GFR_PACKET) &&
                          !oversize;
  wire        expired   = (state_r == GFR_LISTEN) && timed && tick &&
                          (steps_r + 16'h1 == count_r);

  // Step size selection
  assign step_len = (timeout_step_size_i == 2'h0) ? 22'(STEP0_CYC) :
                    (timeout_step_size_i == 2'h1) ? 22'(STEP1_CYC) :
                    (timeout_step_size_i == 2'h2) ? 22'(STEP2_CYC) :
                                                    22'(STEP3_LEN);

  gfr_step_timer u_timer (
    .ref_clk_i  (ref_clk_i),
    .sys_rst_i  (sys_rst_i),
    .run_i      (state_r == GFR_LISTEN && timed),
    .step_len_i (step_len),
    .tick_o     (tick)
  );

  // Receive state sequencing
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      GFR_IDLE: begin
        if (receive_start_cmd_i) begin
          state_nxt = GFR_LISTEN;
        end
      end
      GFR_LISTEN: begin
        if (standby_cmd_i || user_abort_i) begin
          state_nxt = GFR_IDLE;
        end else if (expired) begin
          state_nxt = GFR_IDLE;
        end else if (sync_found_i) begin
          state_nxt = GFR_PACKET;
        end
      end
      GFR_PACKET: begin
        if (standby_cmd_i || user_abort_i || oversize) begin
          state_nxt = (oversize && !standby_cmd_i && !user_abort_i) ?
                      GFR_LISTEN : GFR_IDLE;
        end else if (packet_done_i) begin
          state_nxt = cont_mode ? GFR_LISTEN : GFR_IDLE;
        end
      end
      default: state_nxt = GFR_IDLE;
    endcase
  end

  // Event vector for sticky flags
  always_comb begin
    set_vec = 16'h0000;
    set_vec[PKT_END_BIT] = pkt_end;
    set_vec[SYNC_BIT]    = sync_found_i && (state_r == GFR_LISTEN);
    set_vec[CRC_BIT]     = pkt_end && crc_enable_i && crc_bad_i;
    set_vec[EXPIRY_BIT]  = expired;
  end

  assign flags_nxt = (flags_o & ~(flag_clear_cmd_i ? flag_select_mask_i
                                                    : 16'h0000))
                     | (set_vec & en_r);

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_r <= GFR_IDLE;
      count_r <= 16'h0000;
      steps_r <= 16'h0000;
      flags_o <= 16'h0000;
    end else begin
      state_r <= state_nxt;
      flags_o <= flags_nxt;
      if (receive_start_cmd_i && !in_rx) begin
        count_r <= cmd_count;
      end
      steps_r <= (state_r != GFR_LISTEN) ? 16'h0000 :
                 tick ? steps_r + 16'h1 : steps_r;
    end
  end

  // Routing masks
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      en_r <= 16'h0000;
      m1_r <= 16'h0000;
      m2_r <= 16'h0000;
      m3_r <= 16'h0000;
    end else if (pin_irq_routing_cmd_i) begin
      en_r <= flag_enable_mask_i;
      m1_r <= pin1_mask_i;
      m2_r <= pin2_mask_i;
      m3_r <= pin3_mask_i;
    end
  end

  // Masks as they stand after this edge, so pins never lag a reroute
  wire [15:0] m1_nxt = pin_irq_routing_cmd_i ? pin1_mask_i : m1_r;
  wire [15:0] m2_nxt = pin_irq_routing_cmd_i ? pin2_mask_i : m2_r;
  wire [15:0] m3_nxt = pin_irq_routing_cmd_i ? pin3_mask_i : m3_r;

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pin1_o      <= 1'b0;
      pin2_o      <= 1'b0;
      pin3_o      <= 1'b0;
      receiving_o <= 1'b0;
    end else begin
      pin1_o      <= |(flags_nxt & m1_nxt);
      pin2_o      <= |(flags_nxt & m2_nxt);
      pin3_o      <= |(flags_nxt & m3_nxt);
      receiving_o <= (state_nxt != GFR_IDLE);
    end
  end

  // Packet status capture
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sync_strength_o <= RESET_BYTE;
      status2_o       <= RESET_BYTE;
      status4_o       <= RESET_BYTE;
      len_r           <= RESET_BYTE;
    end else begin
      status2_o[ST_BUSY_BIT] <= (state_nxt == GFR_PACKET);
      status2_o[7]           <= 1'b0;
      if (sync_found_i && state_r == GFR_LISTEN) begin
        sync_strength_o <= strength_i;
        status4_o <= {5'h00, (sync_which_i == CORR_ONE ||
                              sync_which_i == CORR_TWO ||
                              sync_which_i == CORR_THREE) ?
                             sync_which_i : CORR_NONE};
        status2_o[6:1] <= 6'h00;
      end else if (state_r == GFR_PACKET) begin
        if (sync_again_i && multi_sync_en_i) begin
          status2_o[ST_MULTI_BIT] <= 1'b1;
        end
        if (header_i && var_length_i) begin
          status2_o[ST_HDR_BIT] <= 1'b1;
          len_r <= hdr_len_i;
          status2_o[ST_OVER_BIT] <= oversize;
        end
        if (packet_done_i) begin
          status2_o[ST_DONE_BIT] <= 1'b1;
          status2_o[ST_CRC_BIT] <= crc_enable_i && crc_bad_i;
        end
      end
      if (user_abort_i && in_rx) begin
        status2_o[ST_ABORT_BIT] <= 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      payload_len_o        <= RESET_BYTE;
      payload_start_addr_o <= RESET_BYTE;
      packet_store_o       <= 1'b0;
    end else begin
      packet_store_o <= pkt_end;
      if (pkt_end) begin
        payload_len_o        <= var_length_i ? len_r : max_payload_len_i;
        payload_start_addr_o <= rx_base_addr_i;
      end
    end
  end

  a_pin_or_flags: assert property (@(posedge ref_clk_i)
    disable iff (sys_rst_i) pin1_o == |(flags_o & m1_r))
    else $error("pin1 not OR of flags");
  a_pin2_or_flags: assert property (@(posedge ref_clk_i)
    disable iff (sys_rst_i) pin2_o == |(flags_o & m2_r))
    else $error("pin2 not OR of flags");
  a_pin3_or_flags: assert property (@(posedge ref_clk_i)
    disable iff (sys_rst_i) pin3_o == |(flags_o & m3_r))
    else $error("pin3 not OR of flags");
  a_clear_masked: assert property (@(posedge ref_clk_i)
    disable iff (sys_rst_i) flag_clear_cmd_i && set_vec == 16'h0000 |=>
    (flags_o & $past(flag_select_mask_i)) == 16'h0000)
    else $error("masked flag not cleared");
  a_cont_stays: assert property (@(posedge ref_clk_i)
    disable iff (sys_rst_i) pkt_end && cont_mode && !standby_cmd_i &&
    !user_abort_i |=> state_r == GFR_LISTEN)
    else $error("continuous left rx");
  a_single_leaves: assert property (@(posedge ref_clk_i)
    disable iff (sys_rst_i) pkt_end && !cont_mode |=> state_r == GFR_IDLE)
    else $error("did not return to idle");
  a_pkt_end_flag: assert property (@(posedge ref_clk_i)
    disable iff (sys_rst_i) pkt_end && en_r[PKT_END_BIT] |=>
    flags_o[PKT_END_BIT])
    else $error("packet end flag missing");
  a_single_noexp: assert property (@(posedge ref_clk_i)
    disable iff (sys_rst_i) single && state_r == GFR_LISTEN |-> !tick)
    else $error("timer ran in single mode");
  a_timer_halt: assert property (@(posedge ref_clk_i)
    disable iff (sys_rst_i) state_r == GFR_PACKET &&
    $past(state_r) == GFR_PACKET |-> !tick)
    else $error("timer ran in packet");
  a_done_bit: assert property (@(posedge ref_clk_i)
    disable iff (sys_rst_i) pkt_end |=>
    status2_o[ST_DONE_BIT] && packet_store_o)
    else $error("done bit missing");
  a_sync_flag: assert property (@(posedge ref_clk_i)
    disable iff (sys_rst_i) sync_found_i && state_r == GFR_LISTEN &&
    en_r[SYNC_BIT] |=> flags_o[SYNC_BIT])
    else $error("sync flag missing");
  a_crc_flag: assert property (@(posedge ref_clk_i)
    disable iff (sys_rst_i) pkt_end && crc_enable_i && crc_bad_i &&
    en_r[CRC_BIT] |=> flags_o[CRC_BIT] && status2_o[ST_CRC_BIT])
    else $error("checksum flag missing");
  a_expiry_idle: assert property (@(posedge ref_clk_i)
    disable iff (sys_rst_i) expired && en_r[EXPIRY_BIT] |=>
    state_r == GFR_IDLE && flags_o[EXPIRY_BIT])
    else $error("expiry not handled");
  a_strength_latch: assert property (@(posedge ref_clk_i)
    disable iff (sys_rst_i) sync_found_i && state_r == GFR_LISTEN |=>
    sync_strength_o == $past(strength_i))
    else $error("strength not latched");
  a_multi_sync: assert property (@(posedge ref_clk_i)
    disable iff (sys_rst_i) state_r == GFR_PACKET && sync_again_i &&
    multi_sync_en_i |=> status2_o[ST_MULTI_BIT])
    else $error("multi sync bit missing");
  a_len_flag: assert property (@(posedge ref_clk_i)
    disable iff (sys_rst_i) state_r == GFR_PACKET && header_i &&
    var_length_i |=> status2_o[ST_OVER_BIT] == $past(oversize))
    else $error("length bit wrong");
  a_abort_bit: assert property (@(posedge ref_clk_i)
    disable iff (sys_rst_i) user_abort_i && in_rx |=>
    status2_o[ST_ABORT_BIT])
    else $error("abort bit missing");
  a_hdr_bit: assert property (@(posedge ref_clk_i)
    disable iff (sys_rst_i) state_r == GFR_PACKET && header_i &&
    var_length_i |=> status2_o[ST_HDR_BIT])
    else $error("header bit missing");
  a_busy_bit: assert property (@(posedge ref_clk_i)
    disable iff (sys_rst_i) status2_o[ST_BUSY_BIT] == (state_r == GFR_PACKET))
    else $error("busy bit wrong");
  a_corr_code: assert property (@(posedge ref_clk_i)
    disable iff (sys_rst_i) status4_o[7:3] == 5'h00 &&
    (status4_o[2:0] == CORR_NONE || status4_o[2:0] == CORR_ONE ||
     status4_o[2:0] == CORR_TWO || status4_o[2:0] == CORR_THREE))
    else $error("unknown correlator code");
  a_buffer_addr: assert property (@(posedge ref_clk_i)
    disable iff (sys_rst_i) pkt_end |=>
    payload_start_addr_o == $past(rx_base_addr_i))
    else $error("start address wrong");
  a_oversize_drop: assert property (@(posedge ref_clk_i)
    disable iff (sys_rst_i) state_r == GFR_PACKET && oversize &&
    !standby_cmd_i && !user_abort_i |=>
    state_r == GFR_LISTEN && !packet_store_o)
    else $error("oversize packet kept");
  c_cont_rx: cover property (@(posedge ref_clk_i) pkt_end && cont_mode);
  c_expiry: cover property (@(posedge ref_clk_i) expired);
  c_crc_fail: cover property (@(posedge ref_clk_i) set_vec[CRC_BIT]);
  c_oversize: cover property (@(posedge ref_clk_i) oversize && in_rx);
  c_user_abort: cover property (@(posedge ref_clk_i) user_abort_i && in_rx);
endmodule // gfr_rx_ctrl

// >>> test/gfr_host_model.sv
// Purpose: host side model that fetches each stored payload
// Assumes: buffer report is settled in the cycle of the store pulse
// Notes:   fetch request stands one cycle, its fields until next store
`timescale 1ns/1ps
module gfr_host_model (
  // Clock and reset
  input  wire logic       ref_clk_i,
  input  wire logic       sys_rst_i,
  // Buffer report from the block
  input  wire logic       packet_store_i,
  input  wire logic [7:0] payload_len_i,
  input  wire logic [7:0] payload_start_addr_i,
  // Buffer fetch request
  output logic            fetch_req_o,
  output logic [7:0]      fetch_offset_o,
  output logic [7:0]      fetch_count_o
);
  // fetch at reported offset and length
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      fetch_req_o    <= 1'b0;
      fetch_offset_o <= 8'h00;
      fetch_count_o  <= 8'h00;
    end else begin
      fetch_req_o <= packet_store_i;
      if (packet_store_i) begin
        fetch_offset_o <= payload_start_addr_i;
        fetch_count_o  <= payload_len_i;
      end
    end
  end
endmodule // gfr_host_model

// >>> test/gfr_rx_ctrl_test.sv
// Purpose: self-checking bench for the receive packet control
// Assumes: events are one-cycle pulses driven at the falling edge
// Notes:   slowest timeout step shortened to S3 cycles
`timescale 1ns/1ps
module gfr_rx_ctrl_test
  import gfr_pkg::*;
;
  localparam int S3 = 20;
  logic        ref_clk_i, sys_rst_i, receive_start_cmd_i, standby_cmd_i;
  logic        user_abort_i, pin_irq_routing_cmd_i, flag_clear_cmd_i;
  logic        var_length_i, crc_enable_i, multi_sync_en_i, sync_found_i;
  logic        sync_again_i, header_i, packet_done_i, crc_bad_i;
  logic [1:0]  timeout_step_size_i;
  logic [2:0]  sync_which_i;
  logic [7:0]  timeout_step_count_hi_i, timeout_step_count_lo_i;
  logic [7:0]  max_payload_len_i, rx_base_addr_i, strength_i, hdr_len_i;
  logic [15:0] flag_enable_mask_i, pin1_mask_i, pin2_mask_i, pin3_mask_i;
  logic [15:0] flag_select_mask_i, flags_o;
  logic        pin1_o, pin2_o, pin3_o, receiving_o, packet_store_o;
  logic [7:0]  sync_strength_o, status2_o, status4_o;
  logic [7:0]  payload_len_o, payload_start_addr_o, fetch_off, fetch_cnt;
  logic        fetch_req;
  int          errors, n_tests;

  gfr_rx_ctrl #(.STEP3_LEN(S3)) DUT (.ref_clk_i, .sys_rst_i,
    .receive_start_cmd_i, .timeout_step_size_i, .timeout_step_count_hi_i,
    .timeout_step_count_lo_i, .standby_cmd_i, .user_abort_i,
    .pin_irq_routing_cmd_i, .flag_enable_mask_i, .pin1_mask_i,
    .pin2_mask_i, .pin3_mask_i, .flag_clear_cmd_i, .flag_select_mask_i,
    .var_length_i, .crc_enable_i, .multi_sync_en_i, .max_payload_len_i,
    .rx_base_addr_i, .sync_found_i, .sync_which_i, .sync_again_i,
    .strength_i, .header_i, .hdr_len_i, .packet_done_i, .crc_bad_i,
    .flags_o, .pin1_o, .pin2_o, .pin3_o, .receiving_o, .sync_strength_o,
    .status2_o, .status4_o, .payload_len_o, .payload_start_addr_o,
    .packet_store_o);

  gfr_host_model host (.ref_clk_i, .sys_rst_i,
    .packet_store_i(packet_store_o), .payload_len_i(payload_len_o),
    .payload_start_addr_i(payload_start_addr_o), .fetch_req_o(fetch_req),
    .fetch_offset_o(fetch_off), .fetch_count_o(fetch_cnt));

  // Free-running clock
  always #2 ref_clk_i = ~ref_clk_i;

  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic chk(logic [31:0] got, logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic cyc(int n);
    repeat (n) @(negedge ref_clk_i);
  endtask

  // Idle cycle first so one strobe never rises where another fell
  task automatic strobe(ref logic s);
    cyc(1);
    s = 1'b1;
    cyc(1);
    s = 1'b0;
  endtask

  // Expected payload length in the buffer report
  function automatic logic [7:0] exp_len(logic [7:0] hl);
    return var_length_i ? hl : max_payload_len_i;
  endfunction

  // Expected correlator code: only one-hot codes are reported
  function automatic logic [2:0] exp_code(logic [2:0] w);
    return (w == CORR_ONE || w == CORR_TWO || w == CORR_THREE) ?
           w : CORR_NONE;
  endfunction

  task automatic wait_flag(int b, int lim);
    int i;
    i = 0;
    while (flags_o[b] !== 1'b1 && i < lim) begin
      cyc(1);
      i++;
    end
    if (flags_o[b] !== 1'b1) begin
      errors++;
      $display("mismatch at %0t: wait ran out %h %h", $time, flags_o, b);
      tally_and_finish();
    end
  endtask

  task automatic rx_start(logic [1:0] sz, logic [15:0] cnt);
    timeout_step_size_i = sz;
    {timeout_step_count_hi_i, timeout_step_count_lo_i} = cnt;
    strobe(receive_start_cmd_i);
  endtask

  task automatic clr(logic [15:0] m);
    flag_select_mask_i = m;
    strobe(flag_clear_cmd_i);
  endtask

  // One whole packet: sync, header, end, then the host fetch
  task automatic pkt(logic [2:0] w, logic [7:0] len, logic bad);
    logic [7:0] st;
    st = 8'($urandom);
    strength_i = st;
    sync_which_i = w;
    strobe(sync_found_i);
    chk(flags_o[SYNC_BIT], 1);
    chk(status4_o, {5'h00, exp_code(w)});
    chk(sync_strength_o, st);
    chk(status2_o[ST_BUSY_BIT], 1);
    if (multi_sync_en_i) strobe(sync_again_i);
    hdr_len_i = len;
    strobe(header_i);
    chk(status2_o[ST_HDR_BIT], var_length_i);
    crc_bad_i = bad;
    strobe(packet_done_i);
    chk(flags_o[PKT_END_BIT], 1);
    chk(status2_o[ST_DONE_BIT], 1);
    chk(status2_o[ST_CRC_BIT], bad & crc_enable_i);
    chk(status2_o[ST_MULTI_BIT], multi_sync_en_i);
    chk(flags_o[CRC_BIT], bad & crc_enable_i);
    chk(packet_store_o, 1);
    chk(payload_len_o, exp_len(len));
    chk(payload_start_addr_o, rx_base_addr_i);
    chk({pin1_o, pin2_o}, {1'b1, bad & crc_enable_i});
    cyc(1);
    chk({fetch_req, packet_store_o}, 2'h2);
    chk({fetch_off, fetch_cnt}, {rx_base_addr_i, exp_len(len)});
  endtask

  initial begin
    logic [2:0] codes [4];
    // Code 3 is not one-hot and must be reported as none
    codes = '{3'h3, CORR_ONE, CORR_TWO, CORR_THREE};
    ref_clk_i = 1'b0;
    sys_rst_i = 1'b1;
    {receive_start_cmd_i, standby_cmd_i, user_abort_i, flag_clear_cmd_i,
     pin_irq_routing_cmd_i, var_length_i, multi_sync_en_i, sync_found_i,
     sync_again_i, header_i, packet_done_i, crc_bad_i, hdr_len_i,
     timeout_step_size_i, sync_which_i, timeout_step_count_hi_i,
     timeout_step_count_lo_i, strength_i, flag_select_mask_i} = '0;
    crc_enable_i = 1'b1;
    void'($urandom(32'h19E9695E));
    max_payload_len_i = 8'($urandom_range(254, 16));
    rx_base_addr_i = 8'($urandom);
    flag_enable_mask_i = 16'hFFFF;
    pin1_mask_i = (16'h0001 << PKT_END_BIT) | (16'h0001 << SYNC_BIT);
    pin2_mask_i = 16'h0001 << CRC_BIT;
    pin3_mask_i = 16'h0001 << EXPIRY_BIT;
    errors = 0;
    n_tests = 0;
    cyc(4);
    sys_rst_i = 1'b0;
    chk({flags_o, status2_o, 7'h00, receiving_o}, '0);
    strobe(pin_irq_routing_cmd_i);
    // Timed receive, every correlator code, one checksum failure
    for (int k = 0; k < 4; k++) begin
      var_length_i = k[0];
      multi_sync_en_i = (k == 3);
      rx_start(2'($urandom_range(2)), 16'($urandom_range(16'hFFFE, 1)));
      chk(receiving_o, 1);
      pkt(codes[k], 8'($urandom_range(max_payload_len_i)), k == 2);
      chk(receiving_o, 0);
      clr(16'h0001 << SYNC_BIT);
      chk({flags_o[SYNC_BIT], pin1_o}, 2'h1);
      clr(16'hFFFF);
      chk({pin1_o, pin2_o, flags_o}, '0);
    end
    $display("done: timed receive");
    rx_start(2'h0, CNT_CONT);
    // Bad checksum with checking off, then on
    for (int j = 0; j < 2; j++) begin
      crc_enable_i = j[0];
      pkt(CORR_ONE, 8'h01, 1'b1);
      chk(receiving_o, 1);
      clr(16'hFFFF);
    end
    strobe(standby_cmd_i);
    chk(receiving_o, 0);
    $display("done: continuous receive");
    rx_start(2'h3, CNT_SINGLE);
    cyc(100);
    chk({flags_o[EXPIRY_BIT], receiving_o}, 2'h1);
    pkt(CORR_TWO, 8'h02, 1'b0);
    chk(receiving_o, 0);
    clr(16'hFFFF);
    $display("done: single receive");
    rx_start(2'h3, 16'h0003);
    cyc(3 * S3 - 6);
    chk(flags_o[EXPIRY_BIT], 0);
    wait_flag(EXPIRY_BIT, 12);
    chk({pin3_o, receiving_o}, 2'h2);
    clr(16'hFFFF);
    chk(pin3_o, 0);
    $display("done: window expiry");
    rx_start(2'h3, 16'h0002);
    strobe(sync_found_i);
    cyc(3 * S3);
    chk({flags_o[EXPIRY_BIT], receiving_o}, 2'h1);
    strobe(header_i);
    strobe(packet_done_i);
    chk({flags_o[PKT_END_BIT], receiving_o}, 2'h2);
    clr(16'hFFFF);
    $display("done: timer stop");
    rx_start(2'h0, 16'h0005);
    strobe(sync_found_i);
    hdr_len_i = max_payload_len_i + 8'h01;
    strobe(header_i);
    chk(status2_o[ST_OVER_BIT], 1);
    chk({receiving_o, packet_store_o, flags_o[PKT_END_BIT]}, 3'h4);
    strobe(sync_found_i);
    strobe(user_abort_i);
    chk(status2_o[ST_ABORT_BIT], 1);
    strobe(standby_cmd_i);
    chk(receiving_o, 0);
    $display("done: oversize and abort");
    tally_and_finish();
  end
endmodule // gfr_rx_ctrl_test
